/* File: hdl/ep_cfg_pkg.sv */
// Shared constants, field layout and helpers for the endpoint configuration registers.
package ep_cfg_pkg;

  // ----------------------------------------------------------------------------
  // Endpoint indexing
  // ----------------------------------------------------------------------------
  localparam int unsigned NUM_EP      = 16;
  localparam int unsigned EP_IDX_W    = 4;
  localparam int unsigned REG_ADDR_W  = 8;
  localparam int unsigned REG_DATA_W  = 16;

  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFS_FIFO_SIZE = 8'h04;
  localparam logic [7:0] OFS_XFER_CFG  = 8'h08;
  localparam logic [7:0] OFS_PKT_COUNT = 8'h1c;

  // ----------------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------------
  localparam int unsigned FIFO_SIZE_LSB = 0;
  localparam int unsigned FIFO_SIZE_W   = 11;
  localparam int unsigned TRANS_LSB     = 11;
  localparam int unsigned TRANS_W       = 2;
  localparam int unsigned CFG_W         = 5;
  localparam int unsigned CFG_TYPE_LSB  = 0;
  localparam int unsigned CFG_DBL_BIT   = 2;
  localparam int unsigned CFG_EN_BIT    = 3;
  localparam int unsigned CFG_SUPP_BIT  = 4;

  localparam logic [1:0] TYPE_ISO       = 2'h1;
  localparam logic [1:0] TYPE_BULK      = 2'h2;
  localparam logic [1:0] TYPE_INTR      = 2'h3;
  localparam logic [1:0] TRANS_RESERVED = 2'h3;
  localparam logic [1:0] TRANS_ONE      = 2'h1;

  // ----------------------------------------------------------------------------
  // Reset values and memory size
  // ----------------------------------------------------------------------------
  localparam logic [15:0] RST_FIFO_SIZE = 16'h0000;
  localparam logic [15:0] RST_XFER_CFG  = 16'h0000;
  localparam logic [15:0] RST_PKT_COUNT = 16'h0000;
  localparam int unsigned FIFO_MEM_BYTES = 8192;
  localparam int unsigned MEM_ADDR_W     = 14;
  localparam int unsigned ALLOC_SUM_W    = 17;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Index bit 0 is the direction (1 = IN); the upper bits give the endpoint number.
  function automatic logic is_ctrl_ep(input logic [EP_IDX_W-1:0] idx);
    return (idx[EP_IDX_W-1:1] == 3'h0);
  endfunction

endpackage

/* File: hdl/ep_fifo_alloc.sv */
// FIFO memory placement of the enabled data endpoints.
`timescale 1ns/100ps
`default_nettype none
module ep_fifo_alloc (
  input  wire logic                                core_clk_i,   // Core clock.
  input  wire logic                                rst_n_i,      // Synchronous reset, low.
  input  wire logic [ep_cfg_pkg::NUM_EP-1:0][10:0] size_i,       // FIFO size per endpoint.
  input  wire logic [ep_cfg_pkg::NUM_EP-1:0]       enable_i,     // Endpoint enables.
  input  wire logic [ep_cfg_pkg::NUM_EP-1:0]       dbl_i,        // Double buffer selects.
  input  wire logic [ep_cfg_pkg::EP_IDX_W-1:0]     index_i,      // Indexed endpoint.
  output logic      [ep_cfg_pkg::MEM_ADDR_W-1:0]   base_o,       // Base of indexed endpoint.
  output logic                                     overflow_o    // Allocation exceeds memory.
);

  typedef struct packed {
    logic [ep_cfg_pkg::MEM_ADDR_W-1:0] base;
    logic                              overflow;
  } alloc_state_t;

  alloc_state_t st_q;
  alloc_state_t st_d;

  // ----------------------------------------------------------------------------
  // Running sum of the space claimed by lower endpoints
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [ep_cfg_pkg::ALLOC_SUM_W-1:0] sum;
    logic [ep_cfg_pkg::ALLOC_SUM_W-1:0] claim;
    sum   = '0;
    claim = '0;
    st_d  = st_q;
    st_d.base = '0;
    for (int k = 0; k < ep_cfg_pkg::NUM_EP; k++) begin
      if (k == int'(index_i)) begin
        st_d.base = sum[ep_cfg_pkg::MEM_ADDR_W-1:0];
      end
      claim = enable_i[k] ? {6'h0, size_i[k]} : '0;
      if (dbl_i[k]) begin
        claim = {claim[ep_cfg_pkg::ALLOC_SUM_W-2:0], 1'b0};
      end
      sum = sum + claim;
    end
    st_d.overflow = (sum > (ep_cfg_pkg::ALLOC_SUM_W)'(ep_cfg_pkg::FIFO_MEM_BYTES));
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign base_o     = st_q.base;
  assign overflow_o = st_q.overflow;

  AST_ALLOC_DISABLED_EMPTY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (enable_i == '0) |=> (base_o == '0) && !overflow_o)
    else $error("Allocation nonzero with all endpoints disabled.");

endmodule
`default_nettype wire

/* File: hdl/ep_in_fill.sv */
// Byte fill tracking that validates an IN buffer at the packet byte count.
`timescale 1ns/100ps
`default_nettype none
module ep_in_fill (
  input  wire logic        core_clk_i,    // Core clock.
  input  wire logic        rst_n_i,       // Synchronous reset, low.
  input  wire logic        clear_i,       // Restart the fill count.
  input  wire logic        active_i,      // Indexed endpoint is an enabled IN in PIO mode.
  input  wire logic        wr_i,          // Data port write pulse.
  input  wire logic        wr_two_i,      // Write carries two bytes.
  input  wire logic [15:0] limit_i,       // Packet byte count of indexed endpoint.
  output logic      [15:0] fill_o,        // Bytes written so far.
  output logic             validate_o     // Buffer validated, one-cycle pulse.
);

  typedef struct packed {
    logic [15:0] fill;
    logic        validate;
  } fill_state_t;

  fill_state_t st_q;
  fill_state_t st_d;

  always_comb begin
    logic [15:0] nxt;
    nxt  = st_q.fill + (wr_two_i ? 16'h0002 : 16'h0001);
    st_d = st_q;
    st_d.validate = 1'b0;
    if (clear_i) begin
      st_d.fill = '0;
    end else if (wr_i && active_i) begin
      if ((limit_i != 16'h0000) && (nxt >= limit_i)) begin
        st_d.fill     = '0;
        st_d.validate = 1'b1;
      end else begin
        st_d.fill = nxt;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fill_o     = st_q.fill;
  assign validate_o = st_q.validate;

  AST_VALIDATE_AT_COUNT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!clear_i && wr_i && active_i && limit_i != 16'h0000
     && (fill_o + (wr_two_i ? 16'h0002 : 16'h0001)) >= limit_i)
    |=> validate_o && (fill_o == 16'h0000))
    else $error("IN buffer not validated at packet byte count.");

endmodule
`default_nettype wire

/* File: hdl/ep_cfg_regs.sv */
// Per-endpoint FIFO size, transfer configuration and packet byte count registers.
//
// Overview of operation
// - Size settings skip the control endpoint zero.
// - Size write reloads every packet byte count.
// - Bits 12:11 give one to three packets.
// - Packet count only for high-speed iso/interrupt.
// - Bits 10:0 give FIFO size in bytes.
// - Size register bits 15:13 reserved, resets zero.
// - Packet byte count clears on both resets.
// - Zero count or size sends empty packet.
// - Suppress bit disables empty packets, DMA only.
// - Enable bit 3 activates endpoint FIFO.
// - Enabled endpoint gets FIFO memory by size.
// - Re-enable resets toggle.
// - Bit 2 selects two packet buffers.
// - Type field: iso, bulk, interrupt codes.
// - Config bits 15:5 reserved, resets clear it.
// - IN buffer validates at packet byte count, PIO mode only.
// - OUT acknowledge loads received byte count.
`timescale 1ns/100ps
`default_nettype none
module ep_cfg_regs (
  input  wire logic        core_clk_i,             // Core clock, 100 MHz.
  input  wire logic        rst_n_i,                // Power-on reset, synchronous, low.
  input  wire logic        usb_bus_reset_i,        // USB bus reset level.
  input  wire logic [3:0]  ep_index_i,             // Current endpoint index.
  input  wire logic [7:0]  reg_addr_i,             // Register address.
  input  wire logic [15:0] reg_wdata_i,            // Register write data.
  input  wire logic        reg_wr_i,               // Register write strobe.
  input  wire logic        reg_rd_i,               // Register read strobe.
  output logic      [15:0] reg_rdata_o,            // Read data, valid after reg_rd_i.
  input  wire logic        high_speed_i,           // Link runs at high speed.
  input  wire logic        dma_mode_i,             // Endpoints serviced by DMA.
  input  wire logic        in_token_i,             // IN token seen for token_ep_i.
  input  wire logic [3:0]  token_ep_i,             // Endpoint of token or acknowledge.
  input  wire logic        pkt_ack_i,              // Data packet acknowledged.
  input  wire logic [15:0] out_rx_bytes_i,         // Bytes of the acknowledged OUT packet.
  input  wire logic        port_wr_i,              // Data port write pulse.
  input  wire logic        port_wr_two_i,          // Data port write holds two bytes.
  output logic             send_empty_pkt_o,       // Answer IN with empty packet.
  output logic             data_toggle_o,          // Toggle of token_ep_i.
  output logic             buffer_validate_o,      // IN buffer validated.
  output logic [15:0]      ep_enabled_o,           // Enable of every endpoint.
  output logic             ep_double_buffer_o,     // Indexed endpoint double buffered.
  output logic [1:0]       ep_transfer_type_o,     // Indexed endpoint transfer type.
  output logic [1:0]       ep_packets_per_uframe_o,// Packets per microframe, 1 to 3.
  output logic [13:0]      ep_fifo_base_o,         // FIFO base of indexed endpoint.
  output logic             fifo_overflow_o         // Enabled FIFOs exceed memory.
);

  localparam int unsigned N = ep_cfg_pkg::NUM_EP;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0][ep_cfg_pkg::FIFO_SIZE_W-1:0] fifo_size;
    logic [N-1:0][ep_cfg_pkg::TRANS_W-1:0]     transactions_per_microframe;
    logic [N-1:0][ep_cfg_pkg::CFG_W-1:0]       cfg;
    logic [N-1:0][15:0]                        pkt_cnt;
    logic [N-1:0]                              toggle;
    logic [15:0]                               rdata;
    logic                                      empty_pkt;
    logic [3:0]                                idx_prev;
  } cfg_state_t;

  cfg_state_t st_q;
  cfg_state_t st_d;

  logic [N-1:0]                               dbl_vec;
  logic [N-1:0][ep_cfg_pkg::FIFO_SIZE_W-1:0]  alloc_size;
  logic [ep_cfg_pkg::CFG_W-1:0]               cfg_idx;
  logic [ep_cfg_pkg::CFG_W-1:0]               cfg_tok;
  logic                                       supp_eff;
  logic                                       fill_clear;
  logic                                       fill_active;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.empty_pkt = 1'b0;
    st_d.idx_prev  = ep_index_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ep_cfg_pkg::OFS_FIFO_SIZE: begin
          st_d.rdata = {3'h0, st_q.transactions_per_microframe[ep_index_i], st_q.fifo_size[ep_index_i]};
        end
        ep_cfg_pkg::OFS_XFER_CFG: begin
          st_d.rdata = {11'h000, st_q.cfg[ep_index_i]};
        end
        ep_cfg_pkg::OFS_PKT_COUNT: begin
          st_d.rdata = st_q.pkt_cnt[ep_index_i];
        end
        default: begin
          st_d.rdata = 16'h0000;
        end
      endcase
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        ep_cfg_pkg::OFS_FIFO_SIZE: begin
          if (!ep_cfg_pkg::is_ctrl_ep(ep_index_i)) begin
            st_d.fifo_size[ep_index_i] = reg_wdata_i[10:0];
            st_d.transactions_per_microframe[ep_index_i]    = reg_wdata_i[12:11];
          end
          for (int k = 0; k < N; k++) begin
            st_d.pkt_cnt[k] = {5'h00, reg_wdata_i[10:0]};
          end
        end
        ep_cfg_pkg::OFS_XFER_CFG: begin
          st_d.cfg[ep_index_i] = reg_wdata_i[4:0];
        end
        ep_cfg_pkg::OFS_PKT_COUNT: begin
          st_d.pkt_cnt[ep_index_i] = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (pkt_ack_i) begin
      if (!token_ep_i[0]) begin
        st_d.pkt_cnt[token_ep_i] = out_rx_bytes_i;
      end
      st_d.toggle[token_ep_i] = ~st_q.toggle[token_ep_i];
    end
    // A disabled endpoint holds toggle at DATA0, so a later re-enable restarts it.
    for (int k = 0; k < N; k++) begin
      if (!st_d.cfg[k][ep_cfg_pkg::CFG_EN_BIT]) begin
        st_d.toggle[k] = 1'b0;
      end
    end
    if (in_token_i && cfg_tok[ep_cfg_pkg::CFG_EN_BIT] && !supp_eff
        && (st_q.pkt_cnt[token_ep_i] == 16'h0000
            || st_q.fifo_size[token_ep_i] == 11'h000)) begin
      st_d.empty_pkt = 1'b1;
    end
    if (usb_bus_reset_i) begin
      st_d = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Decoded views
  // ----------------------------------------------------------------------------
  function automatic logic [1:0] packets_per_uframe(input logic [ep_cfg_pkg::CFG_W-1:0] cfg,
                                                    input logic [1:0] transactions_per_microframe,
                                                    input logic       hs);
    logic [1:0] typ;
    typ = cfg[1:0];
    if (hs && (typ == ep_cfg_pkg::TYPE_ISO || typ == ep_cfg_pkg::TYPE_INTR)
        && transactions_per_microframe != ep_cfg_pkg::TRANS_RESERVED) begin
      return transactions_per_microframe + 2'h1;
    end
    return ep_cfg_pkg::TRANS_ONE;
  endfunction

  assign cfg_idx  = st_q.cfg[ep_index_i];
  assign cfg_tok  = st_q.cfg[token_ep_i];
  assign supp_eff = cfg_tok[ep_cfg_pkg::CFG_SUPP_BIT] && dma_mode_i;

  for (genvar g = 0; g < N; g++) begin : g_ep
    assign ep_enabled_o[g] = st_q.cfg[g][ep_cfg_pkg::CFG_EN_BIT];
    assign dbl_vec[g]      = st_q.cfg[g][ep_cfg_pkg::CFG_DBL_BIT];
    assign alloc_size[g]   = st_q.fifo_size[g];
  end

  assign reg_rdata_o             = st_q.rdata;
  assign send_empty_pkt_o        = st_q.empty_pkt;
  assign data_toggle_o           = st_q.toggle[token_ep_i];
  assign ep_double_buffer_o      = cfg_idx[ep_cfg_pkg::CFG_DBL_BIT];
  assign ep_transfer_type_o      = cfg_idx[1:0];
  assign ep_packets_per_uframe_o = ep_cfg_pkg::is_ctrl_ep(ep_index_i) ? ep_cfg_pkg::TRANS_ONE
                                 : packets_per_uframe(cfg_idx, st_q.transactions_per_microframe[ep_index_i],
                                                      high_speed_i);

  // ----------------------------------------------------------------------------
  // Memory placement and IN fill tracking
  // ----------------------------------------------------------------------------
  ep_fifo_alloc u_alloc (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .size_i     (alloc_size),
    .enable_i   (ep_enabled_o),
    .dbl_i      (dbl_vec),
    .index_i    (ep_index_i),
    .base_o     (ep_fifo_base_o),
    .overflow_o (fifo_overflow_o)
  );

  assign fill_clear  = usb_bus_reset_i || (ep_index_i != st_q.idx_prev)
                    || (reg_wr_i && reg_addr_i == ep_cfg_pkg::OFS_PKT_COUNT);
  assign fill_active = ep_index_i[0] && cfg_idx[ep_cfg_pkg::CFG_EN_BIT] && !dma_mode_i;

  ep_in_fill u_fill (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (fill_clear),
    .active_i   (fill_active),
    .wr_i       (port_wr_i),
    .wr_two_i   (port_wr_two_i),
    .limit_i    (st_q.pkt_cnt[ep_index_i]),
    .fill_o     (),
    .validate_o (buffer_validate_o)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_cfg_write(logic en);
    reg_wr_i && reg_addr_i == ep_cfg_pkg::OFS_XFER_CFG && reg_wdata_i[3] == en;
  endsequence

  sequence s_quiet;
    !usb_bus_reset_i && !pkt_ack_i;
  endsequence

  AST_CTRL_SIZE_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st_q.fifo_size[0] == 11'h000 && st_q.fifo_size[1] == 11'h000)
    else $error("Control endpoint took a FIFO size.");

  AST_SIZE_RELOADS_ALL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == ep_cfg_pkg::OFS_FIFO_SIZE && !usb_bus_reset_i && !pkt_ack_i)
    |=> st_q.pkt_cnt[N-1] == {5'h00, $past(reg_wdata_i[10:0])}
        && st_q.pkt_cnt[2] == {5'h00, $past(reg_wdata_i[10:0])})
    else $error("Size write did not reload packet byte counts.");

  AST_PPU_DECODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!ep_cfg_pkg::is_ctrl_ep(ep_index_i) && high_speed_i && cfg_idx[1:0] == 2'h1
     && st_q.transactions_per_microframe[ep_index_i] == 2'h2) |-> ep_packets_per_uframe_o == 2'h3)
    else $error("Three packets per microframe not decoded.");

  AST_PPU_BULK_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg_idx[1:0] == 2'h2 || !high_speed_i) |-> ep_packets_per_uframe_o == 2'h1)
    else $error("Transactions setting used outside high-speed iso/interrupt.");

  AST_BUS_RESET_CLEARS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    usb_bus_reset_i |=> (st_q.pkt_cnt == '0) && (st_q.cfg == '0)
                        && (st_q.fifo_size == '0) && (st_q.transactions_per_microframe == '0))
    else $error("Bus reset left a configuration field set.");

  AST_EMPTY_PACKET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (in_token_i && !usb_bus_reset_i && ep_enabled_o[token_ep_i]
     && !(cfg_tok[4] && dma_mode_i) && st_q.pkt_cnt[token_ep_i] == 16'h0000)
    |=> send_empty_pkt_o)
    else $error("Empty packet not produced for zero byte count.");

  AST_SUPPRESS_DMA: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (in_token_i && cfg_tok[4] && dma_mode_i) |=> !send_empty_pkt_o)
    else $error("Empty packet sent while suppressed in DMA mode.");

  AST_ENABLE_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (s_cfg_write(1'b1) ##0 s_quiet) |=> ep_enabled_o[$past(ep_index_i)])
    else $error("Enable write did not activate endpoint.");

  AST_TOGGLE_RESTART: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (s_cfg_write(1'b0) ##2 s_cfg_write(1'b1) ##0 $stable(ep_index_i) ##0 s_quiet)
    |=> st_q.toggle[$past(ep_index_i)] == 1'b0)
    else $error("Toggle not restarted by disable and re-enable.");

  AST_OUT_LOAD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (pkt_ack_i && !token_ep_i[0] && !usb_bus_reset_i)
    |=> st_q.pkt_cnt[$past(token_ep_i)] == $past(out_rx_bytes_i))
    else $error("OUT acknowledge did not load received byte count.");

endmodule
`default_nettype wire

/* File: tb/usb_host_model.sv */
// Behavioural USB host that sends IN tokens and acknowledged OUT packets.
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input  wire logic   core_clk_i,  // Core clock.
  output logic        in_token_o,  // IN token pulse.
  output logic [3:0]  token_ep_o,  // Endpoint of token or acknowledge.
  output logic        pkt_ack_o,   // Acknowledge pulse.
  output logic [15:0] rx_bytes_o   // Received byte count.
);
  initial begin
    in_token_o = 1'b0;
    token_ep_o = 4'h0;
    pkt_ack_o  = 1'b0;
    rx_bytes_o = 16'h0000;
  end
  // The byte count is only valid with the acknowledge, so it is scrambled afterwards.
  task automatic pulse(input logic ack, input logic [3:0] ep, input logic [15:0] n);
    @(posedge core_clk_i) #1;
    token_ep_o = ep;
    rx_bytes_o = n;
    in_token_o = ~ack;
    pkt_ack_o  = ack;
    @(posedge core_clk_i) #1;
    in_token_o = 1'b0;
    pkt_ack_o  = 1'b0;
    rx_bytes_o = ~n;
  endtask
endmodule
`default_nettype wire

/* File: tb/ep_cfg_regs_tb.sv */
// Self-checking bench for the endpoint configuration registers.
`timescale 1ns/100ps
`default_nettype none
module ep_cfg_regs_tb;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        bus_rst = 1'b0;
  logic [3:0]  idx = 4'h0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        hs = 1'b0;
  logic        dma = 1'b0;
  logic        pw = 1'b0;
  logic        pw2 = 1'b0;
  logic        tok, ack, empty, tgl, vld, dbl, ovf;
  logic [3:0]  tep;
  logic [15:0] rxb, rdata, en;
  logic [1:0]  typ, ppu;
  logic [13:0] base;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  usb_host_model i_usb_host_model (.core_clk_i(core_clk_i), .in_token_o(tok),
    .token_ep_o(tep), .pkt_ack_o(ack), .rx_bytes_o(rxb));
  ep_cfg_regs i_ep_cfg_regs (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .usb_bus_reset_i(bus_rst), .ep_index_i(idx), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .high_speed_i(hs),
    .dma_mode_i(dma), .in_token_i(tok), .token_ep_i(tep), .pkt_ack_i(ack),
    .out_rx_bytes_i(rxb), .port_wr_i(pw), .port_wr_two_i(pw2),
    .send_empty_pkt_o(empty), .data_toggle_o(tgl), .buffer_validate_o(vld),
    .ep_enabled_o(en), .ep_double_buffer_o(dbl), .ep_transfer_type_o(typ),
    .ep_packets_per_uframe_o(ppu), .ep_fifo_base_o(base), .fifo_overflow_o(ovf));

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge core_clk_i) #1;
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i) #1;
    addr = a;
    rd = 1'b1;
    @(posedge core_clk_i) #1;
    rd = 1'b0;
    chk(rdata, exp);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    idx = 4'h2;
    rreg(8'h04, 16'h0000);
    rreg(8'h08, 16'h0000);
    rreg(8'h1c, 16'h0000);
    rreg(8'h10, 16'h0000);
    chk(16'(ppu), 16'h0001);
    idx = 4'h0;
    wreg(8'h04, 16'h0123);
    rreg(8'h04, 16'h0000);
    rreg(8'h1c, 16'h0123);
    idx = 4'h2;
    wreg(8'h04, 16'h0840);
    rreg(8'h04, 16'h0840);
    idx = 4'h5;
    rreg(8'h1c, 16'h0040);
    rreg(8'h04, 16'h0000);
    idx = 4'h2;
    wreg(8'h08, 16'hffff);
    rreg(8'h08, 16'h001f);
    chk({14'h0000, en[2], dbl}, 16'h0003);
    hs = 1'b1;
    for (int t = 1; t < 4; t++) begin
      wreg(8'h08, 16'(8 + t));
      chk({13'h0000, dbl, typ}, 16'(t));
      for (int n = 0; n < 4; n++) begin
        wreg(8'h04, 16'((n << 11) + 64));
        chk(16'(ppu), (t == 2 || n == 3) ? 16'h0001 : 16'(n + 1));
      end
    end
    wreg(8'h08, 16'h000e);
    idx = 4'h3;
    wreg(8'h04, 16'h0020);
    wreg(8'h08, 16'h000a);
    @(posedge core_clk_i) #1;
    chk({ovf, 1'b0, base}, 16'h0080);
    i_usb_host_model.pulse(1'b1, 4'h2, 16'h0005);
    chk(16'(tgl), 16'h0001);
    idx = 4'h2;
    rreg(8'h1c, 16'h0005);
    wreg(8'h08, 16'h0006);
    wreg(8'h08, 16'h000e);
    chk(16'(tgl), 16'h0000);
    idx = 4'h3;
    wreg(8'h1c, 16'h0000);
    i_usb_host_model.pulse(1'b0, 4'h3, 16'h0000);
    chk(16'(empty), 16'h0001);
    dma = 1'b1;
    wreg(8'h08, 16'h001a);
    i_usb_host_model.pulse(1'b0, 4'h3, 16'h0000);
    chk(16'(empty), 16'h0000);
    dma = 1'b0;
    i_usb_host_model.pulse(1'b0, 4'h3, 16'h0000);
    chk(16'(empty), 16'h0001);
    wreg(8'h08, 16'h0002);
    i_usb_host_model.pulse(1'b0, 4'h3, 16'h0000);
    chk(16'(empty), 16'h0000);
    wreg(8'h08, 16'h000a);
    wreg(8'h1c, 16'h0003);
    @(posedge core_clk_i) #1;
    pw = 1'b1;
    pw2 = 1'b1;
    @(posedge core_clk_i) #1;
    pw2 = 1'b0;
    chk(16'(vld), 16'h0000);
    @(posedge core_clk_i) #1;
    pw = 1'b0;
    chk(16'(vld), 16'h0001);
    bus_rst = 1'b1;
    @(posedge core_clk_i) #1;
    bus_rst = 1'b0;
    rreg(8'h08, 16'h0000);
    rreg(8'h1c, 16'h0000);
    idx = 4'h2;
    rreg(8'h04, 16'h0000);
    chk(en, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
